// [core/pmi_pkg.sv]
// Constants shared by the power-mode and interrupt control block.
// Assumes a 32-bit APB slave where each register index maps to byte 4*index.
package pmi_pkg;

	// Register indices; the byte address on the bus is four times the index.
	localparam logic [7:0] IDX_IRQ_FLAG   = 8'hC8;
	localparam logic [7:0] IDX_IRQ_ENABLE = 8'hC9;
	localparam logic [7:0] IDX_OSC_MODE   = 8'hCA;
	localparam logic [7:0] IDX_STACK_PTR  = 8'hDF;

	// Interrupt source bit positions, shared by flag and enable registers.
	localparam int BIT_PIN_IRQ     = 0;
	localparam int BIT_TIMER_A_IRQ = 4;
	localparam int BIT_TIMER_B_IRQ = 5;
	localparam int BIT_CONV_IRQ    = 7;
	localparam logic [7:0] IRQ_BITS_MASK = 8'hB1;

	// Stack pointer register layout.
	localparam int GIE_BIT = 7;
	localparam int SP_MSB  = 2;
	localparam logic [2:0] SP_RESET  = 3'h7;
	localparam logic       GIE_RESET = 1'h0;

	// Oscillator and mode register layout.
	localparam int MODE_LSB       = 3;
	localparam int SLOW_SEL_BIT   = 2;
	localparam int HOSC_STOP_BIT  = 1;
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_SLEEP  = 2'h1;
	localparam logic [1:0] MODE_GREEN  = 2'h2;
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [7:0] FLAG_RESET   = 8'h00;

	// Wakeup settling count in fast oscillator clocks, and the vector.
	localparam int          WAKE_CLOCKS = 2048;
	localparam logic [11:0] IRQ_VECTOR  = 12'h008;

	typedef enum logic [3:0] {
		PMI_RUN    = 4'b0001,
		PMI_GREEN  = 4'b0010,
		PMI_SLEEP  = 4'b0100,
		PMI_WARMUP = 4'b1000
	} pmi_state_t;

endpackage

// [core/pmi_sync.sv]
// Three-flop synchroniser with agreement filter for asynchronous inputs.
// Assumes the input may change at any time relative to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module pmi_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk,   // System clock.
	input  wire logic         rst_b,     // Asynchronous reset, active low.
	input  wire logic         clk_en,    // Freezes all state while low.
	input  wire logic [W-1:0] async_in,  // Raw asynchronous input.
	output logic      [W-1:0] stable_q,  // Filtered level.
	output logic              change_q   // One-cycle pulse on accepted change.
);
	logic [W-1:0] meta_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= '0;
			s2_q   <= '0;
			s3_q   <= '0;
		end else if (clk_en) begin
			meta_q <= async_in;
			s2_q   <= meta_q;
			s3_q   <= s2_q;
		end
	end

	// A change only counts once the second and third stages agree.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			stable_q <= '0;
			change_q <= 1'b0;
		end else if (clk_en) begin
			change_q <= (s2_q == s3_q) && (s3_q != stable_q);
			if (s2_q == s3_q) begin
				stable_q <= s3_q;
			end
		end
	end
endmodule
`default_nettype wire

// [core/pmi_wake_cnt.sv]
// Settling counter run after wakeup from power down.
// Assumes ref_clk is the fast oscillator clock once it has started.
`timescale 1ns/1ps
`default_nettype none
module pmi_wake_cnt #(
	parameter int COUNT = 2048
) (
	input  wire logic ref_clk,  // System clock.
	input  wire logic rst_b,    // Asynchronous reset, active low.
	input  wire logic clk_en,   // Freezes all state while low.
	input  wire logic run,      // Count while high, clear while low.
	output logic      done_q    // High once COUNT clocks have been counted.
);
	logic [$clog2(COUNT+1)-1:0] cnt_q;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q  <= '0;
			done_q <= 1'b0;
		end else if (clk_en) begin
			if (!run) begin
				cnt_q  <= '0;
				done_q <= 1'b0;
			end else if (!done_q) begin
				cnt_q  <= cnt_q + 1'b1;
				done_q <= (cnt_q == ($clog2(COUNT+1))'(COUNT - 1));
			end
		end
	end
endmodule
`default_nettype wire

// [core/pmi_ctrl.sv]
// Operating-mode sequencer and interrupt flag/enable logic behind APB.
// Assumes event inputs are one-cycle pulses on ref_clk and that the CPU
// core reports interrupt return; wake pins and oscillator-ready are async.
`timescale 1ns/1ps
`default_nettype none

module pmi_ctrl #(
	parameter int ADDR_W      = 10,
	parameter int WAKE_CLOCKS = pmi_pkg::WAKE_CLOCKS,
	parameter int PORT_W      = 8
) (
	input  wire logic              ref_clk,          // System clock, 125 MHz.
	input  wire logic              rst_b,            // Async reset, active low.
	input  wire logic              clk_en,           // Freezes all state.
	input  wire logic              psel,             // APB select.
	input  wire logic              penable,          // APB enable.
	input  wire logic              pwrite,           // APB write.
	input  wire logic [ADDR_W-1:0] paddr,            // APB byte address.
	input  wire logic [31:0]       pwdata,           // APB write data.
	output logic      [31:0]       prdata,           // APB read data.
	output logic                   pready,           // APB ready.
	output logic                   pslverr,          // APB error.
	input  wire logic [PORT_W-1:0] port0_pins,       // Async wake pins.
	input  wire logic              hosc_ready_pin,   // Async oscillator ready.
	input  wire logic              pin_irq_evt,      // Pin trigger pulse.
	input  wire logic              timer_a_ovf,      // Timer A overflow pulse.
	input  wire logic              timer_b_ovf,      // Timer B overflow pulse.
	input  wire logic              converter_done,   // Converter end pulse.
	input  wire logic              timer_a_enable,   // Timer A running level.
	input  wire logic              return_from_irq_instr_exec,        // Return executed pulse.
	output logic                   irq_take_q,       // Vector load pulse.
	output logic      [11:0]       vector_pc_q,      // Vector address.
	output logic                   cpu_exec,         // CPU may fetch.
	output logic                   sys_clk_slow,     // System on slow RC.
	output logic                   high_osc_run,     // Fast oscillator on.
	output logic                   low_osc_run,      // Slow RC on.
	output logic                   timer_a_allow,    // Timer A may count.
	output logic                   timer_b_allow     // Timer B may count.
);
	pmi_pkg::pmi_state_t state_q;
	pmi_pkg::pmi_state_t state_d;

	logic [7:0] flag_q;
	logic [7:0] enable_q;
	logic       gie_q;
	logic [2:0] sp_q;
	logic [1:0] mode_q;
	logic       slow_q;
	logic       stop_q;

	logic       port_change;
	logic       hosc_ready;
	logic       warm_done;
	logic       wr_en;
	logic [7:0] wdata8;
	logic [7:0] events;
	logic       irq_pending;
	logic       wake_green;

	function automatic logic hit(input logic [ADDR_W-1:0] a,
	                             input logic [7:0] idx);
		hit = (a == ADDR_W'({idx, 2'b00}));
	endfunction

	pmi_sync #(
		.W (PORT_W)
	) u_port_sync (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.clk_en   (clk_en),
		.async_in (port0_pins),
		.stable_q (),
		.change_q (port_change)
	);

	pmi_sync #(
		.W (1)
	) u_hosc_sync (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.clk_en   (clk_en),
		.async_in (hosc_ready_pin),
		.stable_q (hosc_ready),
		.change_q ()
	);

	// Counting starts only once the oscillator reports it has started.
	pmi_wake_cnt #(
		.COUNT (WAKE_CLOCKS)
	) u_wake_cnt (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.clk_en  (clk_en),
		.run     ((state_q == pmi_pkg::PMI_WARMUP) && hosc_ready),
		.done_q  (warm_done)
	);

	// Bus: zero wait states, a write lands at the access-phase edge.
	assign pready = 1'b1;
	assign wr_en  = psel && penable && pwrite && clk_en;
	assign wdata8 = pwdata[7:0];
	assign pslverr = psel && penable && !(hit(paddr, pmi_pkg::IDX_IRQ_FLAG)
		|| hit(paddr, pmi_pkg::IDX_IRQ_ENABLE)
		|| hit(paddr, pmi_pkg::IDX_OSC_MODE)
		|| hit(paddr, pmi_pkg::IDX_STACK_PTR));

	// Read data is captured in the setup phase so it comes from a flop.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata <= 32'h0000_0000;
		end else if (clk_en && psel && !penable) begin
			prdata <= 32'h0000_0000;
			if (hit(paddr, pmi_pkg::IDX_IRQ_FLAG)) begin
				prdata[7:0] <= flag_q;
			end else if (hit(paddr, pmi_pkg::IDX_IRQ_ENABLE)) begin
				prdata[7:0] <= enable_q;
			end else if (hit(paddr, pmi_pkg::IDX_OSC_MODE)) begin
				prdata[pmi_pkg::MODE_LSB+1:pmi_pkg::MODE_LSB] <= mode_q;
				prdata[pmi_pkg::SLOW_SEL_BIT]  <= slow_q;
				prdata[pmi_pkg::HOSC_STOP_BIT] <= stop_q;
			end else if (hit(paddr, pmi_pkg::IDX_STACK_PTR)) begin
				prdata[pmi_pkg::GIE_BIT]     <= gie_q;
				prdata[pmi_pkg::SP_MSB:0]    <= sp_q;
			end
		end
	end

	// Event vector; the pin event is accepted in any state, so an edge that
	// also wakes power down stays latched until execution resumes.
	always_comb begin
		events = 8'h00;
		events[pmi_pkg::BIT_PIN_IRQ]     = pin_irq_evt;
		events[pmi_pkg::BIT_TIMER_A_IRQ] = timer_a_ovf;
		events[pmi_pkg::BIT_TIMER_B_IRQ] = timer_b_ovf;
		events[pmi_pkg::BIT_CONV_IRQ]    = converter_done;
	end

	// Flags set regardless of enable, and a set beats a same-cycle clear.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			flag_q <= pmi_pkg::FLAG_RESET;
		end else if (clk_en) begin
			if (wr_en && hit(paddr, pmi_pkg::IDX_IRQ_FLAG)) begin
				flag_q <= (wdata8 | events) & pmi_pkg::IRQ_BITS_MASK;
			end else begin
				flag_q <= flag_q | (events & pmi_pkg::IRQ_BITS_MASK);
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			enable_q <= pmi_pkg::ENABLE_RESET;
		end else if (clk_en && wr_en
				&& hit(paddr, pmi_pkg::IDX_IRQ_ENABLE)) begin
			enable_q <= wdata8 & pmi_pkg::IRQ_BITS_MASK;
		end
	end

	// One shared vector whatever the number of pending enabled sources.
	assign irq_pending = gie_q && |(flag_q & enable_q);

	// Vectoring only while executing; the pulse itself clears the enable,
	// so at most one take per entry.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_take_q  <= 1'b0;
			vector_pc_q <= 12'h000;
		end else if (clk_en) begin
			irq_take_q <= irq_pending && cpu_exec && !irq_take_q;
			if (irq_pending && cpu_exec && !irq_take_q) begin
				vector_pc_q <= pmi_pkg::IRQ_VECTOR;
			end
		end
	end

	// Hardware stack moves win over a software write in the same cycle.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			gie_q <= pmi_pkg::GIE_RESET;
			sp_q  <= pmi_pkg::SP_RESET;
		end else if (clk_en) begin
			if (irq_take_q) begin
				gie_q <= 1'b0;
				sp_q  <= sp_q - 1'b1;
			end else if (return_from_irq_instr_exec) begin
				gie_q <= 1'b1;
				sp_q  <= sp_q + 1'b1;
			end else if (wr_en && hit(paddr, pmi_pkg::IDX_STACK_PTR)) begin
				gie_q <= wdata8[pmi_pkg::GIE_BIT];
				sp_q  <= wdata8[pmi_pkg::SP_MSB:0];
			end
		end
	end

	// Green ends on a pin change, or on timer A only while it runs.
	assign wake_green = port_change
		|| (timer_a_ovf && timer_a_enable);

	always_comb begin
		state_d = state_q;
		case (state_q)
			pmi_pkg::PMI_RUN: begin
				// Reserved code 11 is held but treated as normal.
				if (mode_q == pmi_pkg::MODE_SLEEP) begin
					state_d = pmi_pkg::PMI_SLEEP;
				end else if (mode_q == pmi_pkg::MODE_GREEN) begin
					state_d = pmi_pkg::PMI_GREEN;
				end
			end
			pmi_pkg::PMI_GREEN: begin
				if (wake_green) begin
					state_d = pmi_pkg::PMI_RUN;
				end
			end
			pmi_pkg::PMI_SLEEP: begin
				if (port_change) begin
					state_d = pmi_pkg::PMI_WARMUP;
				end
			end
			pmi_pkg::PMI_WARMUP: begin
				if (warm_done) begin
					state_d = pmi_pkg::PMI_RUN;
				end
			end
			default: begin
				state_d = pmi_pkg::PMI_RUN;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= pmi_pkg::PMI_RUN;
		end else if (clk_en) begin
			state_q <= state_d;
		end
	end

	// Mode register. The field returns to 00 on wakeup; power-down wakeup
	// also drops slow select and the stop bit so the part resumes normal,
	// while green wakeup keeps slow select and so returns to the prior mode.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q <= pmi_pkg::MODE_NORMAL;
			slow_q <= 1'b0;
			stop_q <= 1'b0;
		end else if (clk_en) begin
			if (state_q == pmi_pkg::PMI_SLEEP && port_change) begin
				mode_q <= pmi_pkg::MODE_NORMAL;
				slow_q <= 1'b0;
				stop_q <= 1'b0;
			end else if (state_q == pmi_pkg::PMI_GREEN && wake_green) begin
				mode_q <= pmi_pkg::MODE_NORMAL;
			end else if (wr_en && hit(paddr, pmi_pkg::IDX_OSC_MODE)
					&& state_q == pmi_pkg::PMI_RUN) begin
				mode_q <= wdata8[pmi_pkg::MODE_LSB+1:pmi_pkg::MODE_LSB];
				slow_q <= wdata8[pmi_pkg::SLOW_SEL_BIT];
				stop_q <= wdata8[pmi_pkg::HOSC_STOP_BIT];
			end
		end
	end

	// The oscillator stop bit only acts while the slow RC drives the system
	// or in green, so normal mode can never lose its own clock.
	assign high_osc_run = (state_q == pmi_pkg::PMI_WARMUP)
		|| (state_q == pmi_pkg::PMI_RUN && (!slow_q || !stop_q))
		|| (state_q == pmi_pkg::PMI_GREEN && !stop_q);
	assign low_osc_run   = (state_q != pmi_pkg::PMI_SLEEP);
	assign sys_clk_slow  = slow_q && (state_q != pmi_pkg::PMI_WARMUP);
	assign cpu_exec      = (state_q == pmi_pkg::PMI_RUN);
	assign timer_a_allow = (state_q == pmi_pkg::PMI_RUN)
		|| (state_q == pmi_pkg::PMI_GREEN);
	assign timer_b_allow = (state_q == pmi_pkg::PMI_RUN);

endmodule
`default_nettype wire

// [sim/pmi_cpu_model.sv]
// Model of the CPU core and the event sources beside the mode block.
// Assumes the bench asks for events on fire and sets the return delay.
`timescale 1ns/1ps
`default_nettype none
module pmi_cpu_model (
	input  wire logic       ref_clk,        // System clock.
	input  wire logic       rst_b,          // Reset, active low.
	input  wire logic [3:0] fire,           // Event request per source.
	input  wire logic [3:0] return_from_irq_instr_dly,       // Take to return, 0 is never.
	input  wire logic       irq_take_q,     // Vector load from the block.
	output logic            pin_irq_evt,    // Pin trigger pulse.
	output logic            timer_a_ovf,    // Timer A overflow pulse.
	output logic            timer_b_ovf,    // Timer B overflow pulse.
	output logic            converter_done, // Converter end pulse.
	output logic            return_from_irq_instr_exec       // Return executed pulse.
);
	logic [3:0] wait_q;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			{converter_done, timer_b_ovf, timer_a_ovf, pin_irq_evt} <= 4'h0;
		end else begin
			{converter_done, timer_b_ovf, timer_a_ovf, pin_irq_evt} <= fire;
		end
	end

	// A slow service routine is modelled by a long delay before return.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			wait_q    <= 4'h0;
			return_from_irq_instr_exec <= 1'b0;
		end else begin
			return_from_irq_instr_exec <= (wait_q == 4'h1);
			if (irq_take_q) begin
				wait_q <= return_from_irq_instr_dly;
			end else if (wait_q != 4'h0) begin
				wait_q <= wait_q - 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

// [sim/pmi_ctrl_checker.sv]
// Concurrent checks on the ports of the mode and interrupt block.
// Assumes one clock domain and is attached by the bind at the foot.
`timescale 1ns/1ps
`default_nettype none
module pmi_ctrl_checker (
	input wire logic        ref_clk,      // System clock.
	input wire logic        rst_b,        // Reset, active low.
	input wire logic        psel,         // APB select.
	input wire logic        return_from_irq_instr_exec,    // Return executed pulse.
	input wire logic        irq_take_q,   // Vector load pulse.
	input wire logic [11:0] vector_pc_q,  // Vector address.
	input wire logic        cpu_exec,     // CPU may fetch.
	input wire logic        sys_clk_slow, // System on slow RC.
	input wire logic        high_osc_run, // Fast oscillator on.
	input wire logic        low_osc_run,  // Slow RC on.
	input wire logic        timer_b_allow // Timer B may count.
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	reset_run_a: assert property ($rose(rst_b) |-> cpu_exec && !sys_clk_slow)
		else $error("not in normal mode after reset");
	vec_addr_a: assert property (irq_take_q |-> vector_pc_q == 12'h008)
		else $error("vector address is not 8");
	take_pulse_a: assert property (irq_take_q |=> !irq_take_q)
		else $error("take pulse longer than one cycle");
	take_exec_a: assert property (irq_take_q |-> $past(cpu_exec))
		else $error("interrupt taken while halted");
	take_block_a: assert property (
		(irq_take_q ##1 (!return_from_irq_instr_exec && !psel)[*3]) |-> !irq_take_q)
		else $error("second take before return");
	sleep_halt_a: assert property (!low_osc_run |-> !cpu_exec && !timer_b_allow)
		else $error("activity with slow RC stopped");
	run_lrc_a: assert property (cpu_exec |-> low_osc_run)
		else $error("executing with slow RC stopped");
	fast_stop_a: assert property (cpu_exec && !high_osc_run |-> sys_clk_slow)
		else $error("fast clock used while stopped");
endmodule

bind pmi_ctrl pmi_ctrl_checker u_chk (.ref_clk, .rst_b, .psel, .return_from_irq_instr_exec,
	.irq_take_q, .vector_pc_q, .cpu_exec, .sys_clk_slow, .high_osc_run,
	.low_osc_run, .timer_b_allow);
`default_nettype wire

// [sim/pmi_ctrl_bench.sv]
// Self-checking bench for the mode and interrupt block over APB.
// Assumes the CPU and event model stands on the far side.
`timescale 1ns/1ps
`default_nettype none
module pmi_ctrl_bench;
	localparam int WK = 8;
	// Short stand-in for the oscillator settling wait that software owes.
	localparam int SETTLE = 16;
	localparam logic [7:0] FL = pmi_pkg::IDX_IRQ_FLAG;
	localparam logic [7:0] EN = pmi_pkg::IDX_IRQ_ENABLE;
	localparam logic [7:0] MD = pmi_pkg::IDX_OSC_MODE;
	localparam logic [7:0] SP = pmi_pkg::IDX_STACK_PTR;
	logic        ref_clk = 1'b0, rst_b = 1'b0, err;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [9:0]  paddr = 10'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic        pready, pslverr, irq_take_q, cpu_exec, sys_clk_slow;
	logic        high_osc_run, low_osc_run, timer_a_allow, timer_b_allow;
	logic [11:0] vector_pc_q;
	logic [7:0]  port0_pins = 8'h00, rd;
	logic        hosc_ready_pin = 1'b1, timer_a_enable = 1'b0;
	logic [3:0]  fire = 4'h0, return_from_irq_instr_dly = 4'h0;
	logic        pin_irq_evt, timer_a_ovf, timer_b_ovf, converter_done, return_from_irq_instr_exec;
	int          err_count = 0, compares = 0, takes = 0, n;

	pmi_ctrl #(.WAKE_CLOCKS(WK)) u_dut (.ref_clk, .rst_b, .clk_en(1'b1),
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.port0_pins, .hosc_ready_pin, .pin_irq_evt, .timer_a_ovf, .timer_b_ovf,
		.converter_done, .timer_a_enable, .return_from_irq_instr_exec, .irq_take_q,
		.vector_pc_q, .cpu_exec, .sys_clk_slow, .high_osc_run, .low_osc_run,
		.timer_a_allow, .timer_b_allow);
	pmi_cpu_model u_cpu (.ref_clk, .rst_b, .fire, .return_from_irq_instr_dly, .irq_take_q,
		.pin_irq_evt, .timer_a_ovf, .timer_b_ovf, .converter_done, .return_from_irq_instr_exec);

	initial forever #4 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (irq_take_q === 1'b1) takes++;

	task automatic complete_run;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h00_0000, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// The write lands at the access edge, so mode outputs are only settled
	// after it; look at them half a cycle later, not in the landing step.
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(idx, 1'b1, d);
		@(negedge ref_clk);
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		apb(idx, 1'b0, 8'h00);
		chk(rd, exp);
	endtask
	// Event pulses land two edges later, so flags are settled on return.
	task automatic pulse(input logic [3:0] m);
		@(posedge ref_clk);
		fire <= m;
		@(posedge ref_clk);
		fire <= 4'h0;
		repeat (2) @(posedge ref_clk);
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		$display("unexpected at %0t: run timed out", $time);
		complete_run();
	end

	initial begin
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		rdc(FL, 8'h00);
		rdc(EN, 8'h00);
		rdc(SP, 8'h07);
		rdc(MD, 8'h00);
		apb(8'h00, 1'b0, 8'h00);
		chk({7'h00, err}, 8'h01);
		wr(EN, 8'hFF);
		rdc(EN, 8'hB1);
		pulse(4'hF);
		rdc(FL, 8'hB1);
		chk(takes[7:0], 8'h00);
		wr(FL, 8'h00);
		rdc(FL, 8'h00);
		return_from_irq_instr_dly <= 4'hC;
		wr(SP, 8'h87);
		pulse(4'h3);
		wr(FL, 8'h00);
		rdc(SP, 8'h06);
		chk(vector_pc_q[7:0], 8'h08);
		repeat (12) @(posedge ref_clk);
		rdc(SP, 8'h87);
		chk(takes[7:0], 8'h01);
		wr(SP, 8'h07);
		wr(MD, 8'h18);
		repeat (2) @(posedge ref_clk);
		chk({7'h00, cpu_exec}, 8'h01);
		wr(MD, 8'h04);
		chk({6'h00, sys_clk_slow, cpu_exec}, 8'h03);
		wr(MD, 8'h06);
		chk({6'h00, high_osc_run, sys_clk_slow}, 8'h01);
		wr(MD, 8'h04);
		repeat (SETTLE) @(posedge ref_clk);
		wr(MD, 8'h00);
		chk({6'h00, high_osc_run, sys_clk_slow}, 8'h02);
		wr(MD, 8'h04);
		wr(MD, 8'h14);
		repeat (2) @(posedge ref_clk);
		chk({5'h00, cpu_exec, low_osc_run, timer_b_allow}, 8'h02);
		pulse(4'h2);
		chk({7'h00, cpu_exec}, 8'h00);
		timer_a_enable <= 1'b1;
		pulse(4'h2);
		chk({6'h00, cpu_exec, sys_clk_slow}, 8'h03);
		rdc(MD, 8'h04);
		timer_a_enable <= 1'b0;
		wr(MD, 8'h00);
		wr(FL, 8'h00);
		wr(EN, 8'h01);
		wr(SP, 8'h87);
		wr(MD, 8'h08);
		hosc_ready_pin <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk({5'h00, cpu_exec, high_osc_run, low_osc_run}, 8'h00);
		pulse(4'h1);
		chk({7'h00, cpu_exec}, 8'h00);
		port0_pins <= 8'h01;
		while (high_osc_run !== 1'b1) @(posedge ref_clk);
		hosc_ready_pin <= 1'b1;
		n = 0;
		while (cpu_exec !== 1'b1) begin
			@(posedge ref_clk);
			n++;
		end
		chk({7'h00, n >= WK + 1 && n <= WK + 7}, 8'h01);
		repeat (3) @(posedge ref_clk);
		chk(takes[7:0], 8'h02);
		rdc(MD, 8'h00);
		rst_b <= 1'b0;
		@(posedge ref_clk);
		rst_b <= 1'b1;
		rdc(SP, 8'h07);
		complete_run();
	end
endmodule
`default_nettype wire
